// >>> hw/conv_ctrl.sv
// successive-approximation converter control with register port
// assumes the core answers with a one-cycle done pulse and a 10-bit result on clk_in
`timescale 1ns/1ps
module conv_ctrl
(
	// clock, reset, enable
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	input  wire logic                     ce_in,
	// register port
	input  wire logic [2:0]               addr_in,
	input  wire logic [7:0]               wdata_in,
	input  wire logic                     wr_in,
	input  wire logic                     rd_in,
	output logic      [7:0]               rdata_out,
	// converter core
	input  wire logic                     core_done_in,
	input  wire logic [9:0]               core_result_in,
	output conv_ctrl_pkg::core_req_t      core_req_out,
	// external trigger pin
	input  wire logic                     hardware_trigger_input_in,
	// interrupts
	output logic                          done_irq_out,
	output logic                          irq_out
);
	import conv_ctrl_pkg::*;

	ctrl_t       ctrl, next_ctrl;                 // control fields
	conv_state_t state, next_state;               // conversion sequencer
	logic        done_flag, next_done_flag;       // conversion_done_flag
	logic [9:0]  result, next_result;             // result registers
	logic [9:0]  compare, next_compare;           // compare value
	logic [1:0]  events, next_events;             // sticky interrupt status
	logic [1:0]  mask, next_mask;                 // interrupt mask
	logic [7:0]  next_rdata;                      // read data
	core_req_t   next_core_req;                   // core request
	logic        next_done_irq;                   // next done interrupt level
	logic        next_irq;                        // next event interrupt level
	logic        trig_s1, trig_s2, trig_s3;       // trigger synchroniser and edge history
	logic        trig_edge;                       // rising trigger event
	logic        sc_write;                        // write to status control
	logic        cmp_true;                        // compare condition
	logic        start_now;                       // begin a conversion this cycle

	// trigger pin synchroniser, third stage for the edge
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end
		else if (ce_in)
		begin
			trig_s1 <= hardware_trigger_input_in;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end

	// decode and compare helpers
	always_comb
	begin
		trig_edge = trig_s2 && !trig_s3;
		sc_write  = wr_in && (addr_in == REG_STATUS_CONTROL);
		// less-than or greater-equal
		cmp_true  = ctrl.cmp_ge ? (core_result_in >= compare) : (core_result_in < compare);
	end

	// next values of all control state
	always_comb
	begin
		next_ctrl     = ctrl;
		next_state    = state;
		next_done_flag = done_flag;
		next_result   = result;
		next_compare  = compare;
		next_events   = events;
		next_mask     = mask;
		next_rdata    = RESET_BYTE;
		start_now     = 1'b0;
		// register writes
		if (wr_in)
		begin
			case (addr_in)
				REG_STATUS_CONTROL:
				begin
					next_ctrl.ien     = wdata_in[IEN_BIT];
					next_ctrl.cont    = wdata_in[CONT_BIT];
					next_ctrl.channel = wdata_in[4:0];
				end
				REG_CONTROL2:
				begin
					next_ctrl.hw_trig = wdata_in[TRIG_BIT];
					next_ctrl.cmp_en  = wdata_in[CMP_EN_BIT];
					next_ctrl.cmp_ge  = wdata_in[CMP_GE_BIT];
				end
				REG_COMPARE_HIGH: next_compare[9:8] = wdata_in[1:0];
				REG_COMPARE_LOW:  next_compare[7:0] = wdata_in;
				REG_IRQ_MASK:     next_mask = wdata_in[1:0];
				default:          ;
			endcase
		end
		// sequencer
		case (state)
			IDLE:
			begin
				// low-power idle after a single conversion
				if (core_done_in)
					next_state = IDLE;
			end
			CONVERTING:
			begin
				if (core_done_in)
				begin
					// compare gates flag and results
					if (!ctrl.cmp_en || cmp_true)
					begin
						next_done_flag = 1'b1;
						next_result    = core_result_in;
					end
					// continuous keeps going, single idles
					next_state = ctrl.cont ? CONVERTING : IDLE;
					start_now  = ctrl.cont;
				end
			end
			default: next_state = IDLE;
		endcase
		// hardware trigger start
		if (ctrl.hw_trig && trig_edge && ctrl.channel != CH_OFF && state == IDLE)
		begin
			next_state = CONVERTING;
			start_now  = 1'b1;
		end
		// write aborts; all-ones channel stops without a new conversion
		if (sc_write)
		begin
			if (state == CONVERTING)
				next_events[EV_ABORT] = 1'b1;
			if (wdata_in[4:0] == CH_OFF)
			begin
				next_state = IDLE;
				start_now  = 1'b0;
			end
			else if (!ctrl.hw_trig)
			begin
				next_state = CONVERTING;
				start_now  = 1'b1;
			end
			else
			begin
				next_state = IDLE;
				start_now  = 1'b0;
			end
		end
		// flag clears; a completing conversion in the same cycle wins over a result-low read, not over a status-control write
		if ((sc_write || (rd_in && addr_in == REG_RESULT_LOW)) &&
		    !(state == CONVERTING && core_done_in && !sc_write && (!ctrl.cmp_en || cmp_true)))
			next_done_flag = 1'b0;
		// sticky events, set wins over write-one clear
		if (wr_in && addr_in == REG_IRQ_STATUS)
			next_events = next_events & ~wdata_in[1:0];
		if (next_done_flag && !done_flag)
			next_events[EV_DONE] = 1'b1;
		if (sc_write && state == CONVERTING)
			next_events[EV_ABORT] = 1'b1;
		// read data
		if (rd_in)
		begin
			case (addr_in)
				REG_STATUS_CONTROL: next_rdata = {done_flag, ctrl.ien, ctrl.cont, ctrl.channel};
				REG_CONTROL2:       next_rdata = {state == CONVERTING, ctrl.hw_trig, ctrl.cmp_en,
				                                  ctrl.cmp_ge, 4'h0};
				REG_RESULT_HIGH:    next_rdata = {6'h00, result[9:8]};
				REG_RESULT_LOW:     next_rdata = result[7:0];
				REG_COMPARE_HIGH:   next_rdata = {6'h00, compare[9:8]};
				REG_COMPARE_LOW:    next_rdata = compare[7:0];
				REG_IRQ_STATUS:     next_rdata = {6'h00, events};
				REG_IRQ_MASK:       next_rdata = {6'h00, mask};
				default:            next_rdata = RESET_BYTE;
			endcase
		end
		// core request; reserved code is passed but never an input
		next_core_req.start   = start_now;
		next_core_req.power   = (next_ctrl.channel != CH_OFF) && (next_state == CONVERTING);
		next_core_req.channel = next_ctrl.channel;
		// interrupt levels follow the next flag, enable and events
		next_done_irq = next_done_flag && next_ctrl.ien;
		next_irq      = |(next_events & next_mask);
	end

	// control fields, written by software only
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// channel resets to the off code, converter powered down
			ctrl <= '{ien: 1'b0, cont: 1'b0, channel: CH_OFF, hw_trig: 1'b0, cmp_en: 1'b0, cmp_ge: 1'b0};
		end
		else if (ce_in)
		begin
			// held while the clock enable is low
			ctrl <= next_ctrl;
		end
	end

	// conversion sequencer state
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// no conversion in progress after reset
			state <= IDLE;
		end
		else if (ce_in)
		begin
			// frozen mid-conversion while disabled
			state <= next_state;
		end
	end

	// completion flag and result registers
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// nothing converted yet
			done_flag <= 1'b0;
			result    <= RESET_WORD;
		end
		else if (ce_in)
		begin
			// result only moves together with a qualified completion
			done_flag <= next_done_flag;
			result    <= next_result;
		end
	end

	// compare value
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// compare threshold cleared
			compare <= RESET_WORD;
		end
		else if (ce_in)
		begin
			// written a byte at a time by software
			compare <= next_compare;
		end
	end

	// sticky events and their mask
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// no pending events, all masked
			events <= RESET_EVENTS;
			mask   <= RESET_EVENTS;
		end
		else if (ce_in)
		begin
			// set wins over a write-one clear in the same cycle
			events <= next_events;
			mask   <= next_mask;
		end
	end

	// read data, valid only in the cycle after a read strobe
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// bus reads as zero
			rdata_out <= RESET_BYTE;
		end
		else if (ce_in)
		begin
			// zero again one cycle after the read
			rdata_out <= next_rdata;
		end
	end

	// request to the converter core
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// core off, no start, off code on the channel
			core_req_out <= '{start: 1'b0, power: 1'b0, channel: CH_OFF};
		end
		else if (ce_in)
		begin
			// start is a one-cycle pulse
			core_req_out <= next_core_req;
		end
	end

	// interrupt outputs
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// both interrupt lines low
			done_irq_out <= 1'b0;
			irq_out      <= 1'b0;
		end
		else if (ce_in)
		begin
			// levels, held until their cause is cleared
			done_irq_out <= next_done_irq;
			irq_out      <= next_irq;
		end
	end
endmodule // conv_ctrl

// >>> hw/conv_ctrl_pkg.sv
// constants, register map and carrier types of the converter control block
// assumes one 20 MHz bus clock and an 8-bit plain register port
package conv_ctrl_pkg;
	// register indices on the 8-bit port
	localparam logic [2:0] REG_STATUS_CONTROL = 3'h0; // conversion_status_control
	localparam logic [2:0] REG_CONTROL2       = 3'h1; // trigger, compare, active
	localparam logic [2:0] REG_RESULT_HIGH    = 3'h2; // result_high_register
	localparam logic [2:0] REG_RESULT_LOW     = 3'h3; // result_low_register
	localparam logic [2:0] REG_COMPARE_HIGH   = 3'h4; // compare value upper bits
	localparam logic [2:0] REG_COMPARE_LOW    = 3'h5; // compare value lower bits
	localparam logic [2:0] REG_IRQ_STATUS     = 3'h6; // sticky events, write one to clear
	localparam logic [2:0] REG_IRQ_MASK       = 3'h7; // event mask
	// field positions
	localparam int DONE_BIT   = 7;
	localparam int IEN_BIT    = 6;
	localparam int CONT_BIT   = 5;
	localparam int ACTIVE_BIT = 7;
	localparam int TRIG_BIT   = 6;
	localparam int CMP_EN_BIT = 5;
	localparam int CMP_GE_BIT = 4;
	// channel codes
	localparam logic [4:0] CH_LAST_INPUT = 5'h1B;
	localparam logic [4:0] CH_RESERVED   = 5'h1C;
	localparam logic [4:0] CH_REF_HIGH   = 5'h1D;
	localparam logic [4:0] CH_REF_LOW    = 5'h1E;
	localparam logic [4:0] CH_OFF        = 5'h1F;
	// reset values
	localparam logic [7:0] RESET_STATUS_CONTROL = 8'h1F;
	localparam logic [7:0] RESET_BYTE           = 8'h00;
	localparam logic [9:0] RESET_WORD           = 10'h000;
	localparam logic [1:0] RESET_EVENTS         = 2'h0;
	// interrupt event bits
	localparam int EV_DONE  = 0;
	localparam int EV_ABORT = 1;
	typedef enum logic [1:0] { IDLE, CONVERTING } conv_state_t;
	// software side control fields
	typedef struct packed {
		logic       ien;
		logic       cont;
		logic [4:0] channel;
		logic       hw_trig;
		logic       cmp_en;
		logic       cmp_ge;
	} ctrl_t;
	// request to the converter core
	typedef struct packed {
		logic       start;
		logic       power;
		logic [4:0] channel;
	} core_req_t;
endpackage

// >>> verification/core_model.sv
// converter core stand-in: done pulse four cycles after each start
// assumes start is a one-cycle pulse on clk_in
`timescale 1ns/1ps
module core_model
(
	// clock and request
	input  wire logic                     clk_in,
	input  wire conv_ctrl_pkg::core_req_t req_in,
	input  wire logic [9:0]               res_in,
	// answer
	output logic                          done_out,
	output logic [9:0]                    result_out
);
	import conv_ctrl_pkg::*;
	int cnt = 0; // cycles left, 0 when idle
	// a new start restarts the count, power off cancels it
	always @(posedge clk_in)
	begin
		// a powered-down or restarted core never completes
		done_out <= (cnt == 1) && (req_in.power === 1'b1) && (req_in.start !== 1'b1);
		result_out <= (cnt == 1) ? res_in : ~res_in; // no stale value between answers
		if (req_in.start === 1'b1)
			cnt <= 4;
		else if (req_in.power !== 1'b1)
			cnt <= 0;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule // core_model

// >>> verification/conv_ctrl_checker.sv
// port assertions for the conversion control
// assumes one clock; control bits are mirrored from the writes seen
`timescale 1ns/1ps
module conv_ctrl_checker
(
	// clock and reset
	input wire logic                     clk_in,
	input wire logic                     rst_in,
	input wire logic                     ce_in,
	// register port
	input wire logic [2:0]               addr_in,
	input wire logic [7:0]               wdata_in,
	input wire logic                     wr_in,
	input wire logic                     rd_in,
	// core and interrupt
	input wire logic                     core_done_in,
	input wire conv_ctrl_pkg::core_req_t core_req_out,
	input wire logic                     done_irq_out
);
	import conv_ctrl_pkg::*;
	logic ien, cont, hw, cmp; // mirrored control bits
	wire  sc_wr = ce_in && wr_in && addr_in == REG_STATUS_CONTROL; // status control write
	wire  c2_wr = ce_in && wr_in && addr_in == REG_CONTROL2; // control2 write
	// mirror of the bits that gate the checks
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
			{ien, cont, hw, cmp} <= 4'h0;
		else
		begin
			if (sc_wr)
				{ien, cont} <= wdata_in[6:5];
			if (c2_wr)
				{hw, cmp} <= {wdata_in[TRIG_BIT], wdata_in[CMP_EN_BIT]};
		end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_done_ev;
		ce_in && core_done_in && !sc_wr;
	endsequence
	sequence s_restart;
		##[1:3] core_req_out.start;
	endsequence
	a_write_starts: assert property (sc_wr && wdata_in[4:0] != CH_OFF && !hw |=> core_req_out.start
		&& core_req_out.channel == $past(wdata_in[4:0])) else $error("write did not start");
	a_off_no_start: assert property (sc_wr && wdata_in[4:0] == CH_OFF |=>
		!core_req_out.start && !core_req_out.power) else $error("off code still runs");
	a_done_clear: assert property (sc_wr |=> !done_irq_out) else $error("write kept done");
	a_irq_hold: assert property (done_irq_out && !sc_wr && !(rd_in && addr_in == REG_RESULT_LOW)
		|=> done_irq_out) else $error("done irq dropped");
	a_ien_off: assert property (!ien && !sc_wr |=> !done_irq_out) else $error("irq while disabled");
	a_done_irq_set: assert property (s_done_ev ##0 (ien && !cmp) |=> done_irq_out)
		else $error("done irq missing");
	a_single_idle: assert property (s_done_ev ##0 (!cont && !hw) |=> !core_req_out.start)
		else $error("single mode restarted");
	a_cont_restart: assert property (s_done_ev ##0 (cont && !hw) |-> s_restart)
		else $error("continuous mode stalled");
endmodule // conv_ctrl_checker
bind conv_ctrl conv_ctrl_checker chk_u (.clk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.core_done_in, .core_req_out, .done_irq_out);

// >>> verification/tb.sv
// self-checking bench for conv_ctrl with the core stand-in
// assumes core_model answers four cycles after a start
`timescale 1ns/1ps
module tb;
	import conv_ctrl_pkg::*;
	logic       clk_in = 0;        // 20 MHz bus clock
	logic       rst_in = 1;        // reset, high at start
	logic [2:0] addr = 0;          // register index
	logic [7:0] wdata = 0;         // write data
	logic       wr = 0;            // write strobe
	logic       rd = 0;            // read strobe
	logic       trig = 0;          // trigger pin
	logic       ce = 1;            // clock enable
	logic [9:0] res = 10'h2A5;     // value the core converts
	logic [7:0] rdata;             // read data
	logic       done;              // core done pulse
	logic       dirq;              // done interrupt
	logic       irq;               // event interrupt
	logic [9:0] cres;              // core result
	core_req_t  req;               // core request
	int         fails = 0;         // mismatches
	int         comparisons = 0;   // compares made
	int         starts = 0;        // start pulses seen
	int         cyc = 0;           // cycle count for timeout
	int         s;                 // start count snapshot
	always #25 clk_in = ~clk_in;
	conv_ctrl dut_u (.clk_in, .rst_in, .ce_in(ce), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .core_done_in(done), .core_result_in(cres), .core_req_out(req),
		.hardware_trigger_input_in(trig), .done_irq_out(dirq), .irq_out(irq));
	core_model core_u (.clk_in, .req_in(req), .res_in(res), .done_out(done), .result_out(cres));
	// start counting and hang cut-off
	always @(posedge clk_in)
	begin
		if (req.start === 1'b1)
			starts <= starts + 1;
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			fails++;
			end_sim();
		end
	end
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		#1;
	endtask
	// read data is looked at in the cycle after the strobe only
	task automatic bus_rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk({2'h0, rdata}, {2'h0, exp});
	endtask
	task automatic wait_done();
		for (int i = 0; i < 40 && done !== 1'b1; i++)
			@(posedge clk_in);
		@(posedge clk_in);
		#1;
	endtask
	// single software conversion, flag, result, interrupt mask and clear
	task automatic sc_single();
		s = starts;
		bus_wr(REG_STATUS_CONTROL, 8'h45);
		chk(req.channel, 5'h05);
		wait_done();
		chk(dirq, 1'b1);
		bus_rd(REG_STATUS_CONTROL, 8'hC5);
		chk(irq, 1'b0);
		bus_wr(REG_IRQ_MASK, 8'h01);
		bus_rd(REG_RESULT_HIGH, 8'h02);
		chk(irq, 1'b1);
		bus_rd(REG_RESULT_LOW, 8'hA5);
		bus_rd(REG_STATUS_CONTROL, 8'h45);
		bus_wr(REG_IRQ_STATUS, 8'h01);
		bus_rd(REG_IRQ_STATUS, 8'h00);
		chk(irq, 1'b0);
		chk(starts == s + 1, 1'b1);
	endtask
	// compare false keeps flag and result, both directions true
	task automatic sc_compare();
		res = 10'h1FF;
		bus_wr(REG_COMPARE_LOW, 8'h10);
		bus_wr(REG_CONTROL2, 8'h20);
		bus_wr(REG_STATUS_CONTROL, 8'h05);
		bus_rd(REG_CONTROL2, 8'hA0);
		wait_done();
		bus_rd(REG_CONTROL2, 8'h20);
		bus_rd(REG_STATUS_CONTROL, 8'h05);
		bus_rd(REG_RESULT_LOW, 8'hA5);
		bus_wr(REG_CONTROL2, 8'h30);
		bus_wr(REG_STATUS_CONTROL, 8'h05);
		wait_done();
		bus_rd(REG_STATUS_CONTROL, 8'h85);
		bus_rd(REG_RESULT_LOW, 8'hFF);
		res = 10'h008;
		bus_wr(REG_CONTROL2, 8'h20);
		bus_wr(REG_STATUS_CONTROL, 8'h05);
		wait_done();
		bus_rd(REG_RESULT_LOW, 8'h08);
		bus_wr(REG_CONTROL2, 8'h00);
	endtask
	// continuous runs, stopped by the off code (cont bit kept set)
	task automatic sc_cont(input logic [7:0] c2, input logic pulse);
		bus_wr(REG_CONTROL2, c2);
		bus_wr(REG_STATUS_CONTROL, 8'h23);
		s = starts;
		@(posedge clk_in);
		trig <= pulse;
		repeat (30) @(posedge clk_in);
		trig <= 1'b0;
		chk(starts > s + 3, 1'b1);
		bus_wr(REG_STATUS_CONTROL, 8'h3F);
		chk(req.power, 1'b0);
		s = starts;
		repeat (20) @(posedge clk_in);
		chk(starts == s, 1'b1);
		bus_rd(REG_CONTROL2, c2);
		bus_rd(REG_IRQ_STATUS, 8'h03);
		bus_wr(REG_IRQ_STATUS, 8'h03);
	endtask
	// single hardware trigger: a write only idles, the pin starts one
	task automatic sc_hw();
		bus_wr(REG_CONTROL2, 8'h40);
		bus_wr(REG_STATUS_CONTROL, 8'h02);
		chk(req.start, 1'b0);
		s = starts;
		@(posedge clk_in);
		trig <= 1'b1;
		repeat (5) @(posedge clk_in);
		trig <= 1'b0;
		#1;
		chk(starts == s + 1, 1'b1);
		chk(req.channel, 5'h02);
		repeat (20) @(posedge clk_in);
		chk(starts == s + 1, 1'b1);
	endtask
	// every code except the off code is passed to the core and starts a conversion
	task automatic sc_channels();
		for (int c = 0; c < 31; c++)
		begin
			bus_wr(REG_STATUS_CONTROL, 8'(c));
			chk(req.channel, 10'(c));
			chk(req.start, 1'b1);
		end
		bus_wr(REG_STATUS_CONTROL, 8'h1F);
	endtask
	// a write with the clock enable low changes nothing
	task automatic sc_freeze();
		@(posedge clk_in);
		ce <= 1'b0;
		bus_wr(REG_STATUS_CONTROL, 8'h07);
		chk(req.start, 1'b0);
		@(posedge clk_in);
		ce <= 1'b1;
		bus_rd(REG_STATUS_CONTROL, 8'h1F);
	endtask
	task automatic end_sim();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		bus_rd(REG_STATUS_CONTROL, RESET_STATUS_CONTROL);
		bus_rd(REG_IRQ_STATUS, RESET_BYTE);
		sc_single();
		sc_compare();
		sc_cont(8'h00, 1'b0);
		sc_cont(8'h40, 1'b1);
		sc_hw();
		bus_wr(REG_CONTROL2, 8'h00);
		sc_channels();
		sc_freeze();
		end_sim();
	end
endmodule // tb
